/* core/ssm_link_if.sv */
`default_nettype none
interface ssm_link_if;
	logic dev_ck_o;
	logic dev_ck_oe;
	logic dev_dt_o;
	logic dev_dt_oe;
	logic slv_dt_o;
	logic slv_dt_oe;
	logic ck;
	logic dt;
	// Clock line idles low, data line is pulled high when nobody drives it
	assign ck = dev_ck_oe ? dev_ck_o : 1'b0;
	assign dt = dev_dt_oe ? dev_dt_o : (slv_dt_oe ? slv_dt_o : 1'b1);
	modport dev (output dev_ck_o, output dev_ck_oe, output dev_dt_o, output dev_dt_oe,
		input ck, input dt);
	modport slv (output slv_dt_o, output slv_dt_oe, input ck, input dt);
endinterface
`default_nettype wire

/* core/ssm_pkg.sv */
`default_nettype none
package ssm_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_BAUD   = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_RXDATA = 8'h10;
	// Control register field positions
	localparam int CTRL_SYNC_SELECT  = 0;
	localparam int CTRL_CLOCK_SOURCE = 1;
	localparam int CTRL_PORT_ENABLE  = 2;
	localparam int CTRL_SINGLE_RX    = 3;
	localparam int CTRL_CONT_RX      = 4;
	localparam int CTRL_TX_ENABLE    = 5;
	localparam int CTRL_NINE_BIT     = 6;
	localparam int CTRL_NINTH_DATA   = 7;
	localparam int CTRL_HIGH_SPEED   = 8;
	localparam int CTRL_TX_INT_EN    = 9;
	localparam int CTRL_W            = 10;
	// Status register field positions
	localparam int STAT_TX_READY = 0;
	localparam int STAT_BUSY     = 1;
	localparam int STAT_RX_DONE  = 2;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
	localparam logic [7:0]        BAUD_RST = 8'h0F;
	// Character widths and link states
	localparam logic [3:0] BITS_NORMAL = 4'h8;
	localparam logic [3:0] BITS_NINE   = 4'h9;
	typedef enum logic [1:0] {
		SSM_IDLE = 2'b00,
		SSM_TX   = 2'b01,
		SSM_RX   = 2'b11
	} ssm_link_e;
endpackage
`default_nettype wire

/* core/ssm_port.sv */
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
module ssm_port (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             tx_ready_o,
	output logic             tx_irq_o,
	ssm_link_if.dev          link
);
	localparam int CW = ssm_pkg::CTRL_W;

	typedef struct packed {
		ssm_pkg::ssm_link_e st;
		logic [CW-1:0]      ctrl;
		logic [7:0]         div;
		logic [9:0]         baud_rate_generator;
		logic [8:0]         hold;
		logic               hold_full;
		logic [8:0]         sh;
		logic [3:0]         cnt;
		logic [8:0]         rx_sh;
		logic [8:0]         rx_data;
		logic               rx_done;
		logic               ck;
		logic               dt;
		logic               ck_s1;
		logic               ck_s2;
		logic               ck_s3;
		logic               dt_s1;
		logic               dt_s2;
		logic [31:0]        prdata;
	} ssm_dev_s;

	ssm_dev_s s_r;
	ssm_dev_s s_nxt;

	logic       en;
	logic       master;
	logic       txmode;
	logic       transmit_enable_bit;
	logic [3:0] nbits;
	logic [9:0] brg_load;
	logic       tick;
	logic       lead;
	logic       trail;
	logic [8:0] rx_new;
	logic       acc;
	logic       setup;

	always_comb begin
		en     = s_r.ctrl[ssm_pkg::CTRL_PORT_ENABLE] & s_r.ctrl[ssm_pkg::CTRL_SYNC_SELECT];
		master = s_r.ctrl[ssm_pkg::CTRL_CLOCK_SOURCE];
		txmode = ~s_r.ctrl[ssm_pkg::CTRL_SINGLE_RX] & ~s_r.ctrl[ssm_pkg::CTRL_CONT_RX];
		transmit_enable_bit   = s_r.ctrl[ssm_pkg::CTRL_TX_ENABLE];
		nbits  = s_r.ctrl[ssm_pkg::CTRL_NINE_BIT] ? ssm_pkg::BITS_NINE : ssm_pkg::BITS_NORMAL;
		// Half bit period is (div+1) cycles, or four times that at low speed
		brg_load = s_r.ctrl[ssm_pkg::CTRL_HIGH_SPEED] ? {2'b00, s_r.div} : {s_r.div, 2'b11};
		tick   = (s_r.baud_rate_generator == 10'h000);
		// Master edges come from the divider, slave edges from the pin
		if (master) begin
			lead  = tick & ~s_r.ck;
			trail = tick & s_r.ck;
		end else begin
			lead  = s_r.ck_s2 & ~s_r.ck_s3;
			trail = ~s_r.ck_s2 & s_r.ck_s3;
		end
		rx_new = {s_r.dt_s2, s_r.rx_sh[8:1]};
		setup  = psel_i & ~penable_i;
		acc    = psel_i & penable_i;

		s_nxt = s_r;
		s_nxt.ck_s1 = link.ck;
		s_nxt.ck_s2 = s_r.ck_s1;
		s_nxt.ck_s3 = s_r.ck_s2;
		s_nxt.dt_s1 = link.dt;
		s_nxt.dt_s2 = s_r.dt_s1;

		if (s_r.st == ssm_pkg::SSM_IDLE || tick)
			s_nxt.baud_rate_generator = brg_load;
		else
			s_nxt.baud_rate_generator = s_r.baud_rate_generator - 10'h001;
		// Clock toggles only inside a character, so no spare edges
		if (master && s_r.st != ssm_pkg::SSM_IDLE && tick)
			s_nxt.ck = ~s_r.ck;

		unique case (s_r.st)
			ssm_pkg::SSM_IDLE: begin
				s_nxt.ck = 1'b0;
				if (en && txmode && transmit_enable_bit && s_r.hold_full) begin
					s_nxt.sh        = s_r.hold;
					s_nxt.hold_full = 1'b0;
					s_nxt.cnt       = nbits;
					s_nxt.st        = ssm_pkg::SSM_TX;
				end else if (en && !txmode) begin
					s_nxt.cnt = nbits;
					s_nxt.st  = ssm_pkg::SSM_RX;
				end
			end
			ssm_pkg::SSM_TX: begin
				if (!en || !txmode || !transmit_enable_bit) begin
					s_nxt.st = ssm_pkg::SSM_IDLE;
				end else if (lead) begin
					s_nxt.dt = s_r.sh[0];
				end else if (trail) begin
					s_nxt.sh  = {1'b0, s_r.sh[8:1]};
					s_nxt.cnt = s_r.cnt - 4'h1;
					if (s_r.cnt == 4'h1) begin
						if (s_r.hold_full) begin
							s_nxt.sh        = s_r.hold;
							s_nxt.hold_full = 1'b0;
							s_nxt.cnt       = nbits;
						end else begin
							s_nxt.st = ssm_pkg::SSM_IDLE;
						end
					end
				end
			end
			ssm_pkg::SSM_RX: begin
				if (!en || txmode) begin
					s_nxt.st = ssm_pkg::SSM_IDLE;
				end else if (trail) begin
					s_nxt.rx_sh = rx_new;
					s_nxt.cnt   = s_r.cnt - 4'h1;
					if (s_r.cnt == 4'h1) begin
						s_nxt.rx_data = (nbits == ssm_pkg::BITS_NINE) ? rx_new
							: {1'b0, rx_new[8:1]};
						s_nxt.rx_done = 1'b1;
						s_nxt.cnt     = nbits;
						s_nxt.ctrl[ssm_pkg::CTRL_SINGLE_RX] = 1'b0;
						if (!s_r.ctrl[ssm_pkg::CTRL_CONT_RX])
							s_nxt.st = ssm_pkg::SSM_IDLE;
					end
				end
			end
		endcase

		// Read data is latched in setup so it comes from a flop with no wait state
		if (setup) begin
			s_nxt.prdata = 32'h0000_0000;
			unique case (paddr_i)
				ssm_pkg::ADDR_CTRL:   s_nxt.prdata[CW-1:0] = s_r.ctrl;
				ssm_pkg::ADDR_BAUD:   s_nxt.prdata[7:0] = s_r.div;
				ssm_pkg::ADDR_TXDATA: s_nxt.prdata[8:0] = s_r.hold;
				ssm_pkg::ADDR_STATUS: begin
					s_nxt.prdata[ssm_pkg::STAT_TX_READY] = ~s_r.hold_full;
					s_nxt.prdata[ssm_pkg::STAT_BUSY] = (s_r.st != ssm_pkg::SSM_IDLE);
					s_nxt.prdata[ssm_pkg::STAT_RX_DONE] = s_r.rx_done;
				end
				ssm_pkg::ADDR_RXDATA: s_nxt.prdata[8:0] = s_r.rx_data;
				default:              s_nxt.prdata = 32'h0000_0000;
			endcase
		end
		// Software writes override the engine's own updates in the same cycle
		if (acc && pwrite_i) begin
			unique case (paddr_i)
				ssm_pkg::ADDR_CTRL: s_nxt.ctrl = pwdata_i[CW-1:0];
				ssm_pkg::ADDR_BAUD: s_nxt.div = pwdata_i[7:0];
				ssm_pkg::ADDR_TXDATA: begin
					// Ninth bit is captured with the character, so load it first
					s_nxt.hold = {s_r.ctrl[ssm_pkg::CTRL_NINTH_DATA], pwdata_i[7:0]};
					s_nxt.hold_full = 1'b1;
				end
				default: ;
			endcase
		end
		// A fresh character beats the read clear of the done flag
		if (acc && !pwrite_i && paddr_i == ssm_pkg::ADDR_RXDATA &&
			!(s_r.st == ssm_pkg::SSM_RX && trail && s_r.cnt == 4'h1))
			s_nxt.rx_done = 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r      <= '0;
			s_r.st   <= ssm_pkg::SSM_IDLE;
			s_r.ctrl <= ssm_pkg::CTRL_RST;
			s_r.div  <= ssm_pkg::BAUD_RST;
			s_r.ck_s1 <= 1'b0;
			s_r.dt_s1 <= 1'b1;
			s_r.dt_s2 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Shift register has no address, hence no path to prdata
	assign prdata_o  = s_r.prdata;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~(paddr_i == ssm_pkg::ADDR_CTRL ||
		paddr_i == ssm_pkg::ADDR_BAUD || paddr_i == ssm_pkg::ADDR_TXDATA ||
		paddr_i == ssm_pkg::ADDR_STATUS || paddr_i == ssm_pkg::ADDR_RXDATA);
	assign tx_ready_o = ~s_r.hold_full;
	assign tx_irq_o   = ~s_r.hold_full & s_r.ctrl[ssm_pkg::CTRL_TX_INT_EN];

	assign link.dev_ck_o  = s_r.ck;
	assign link.dev_ck_oe = en & master;
	assign link.dev_dt_o  = s_r.dt;
	assign link.dev_dt_oe = en & txmode & transmit_enable_bit;
endmodule // ssm_port
`default_nettype wire

/* core/ssm_slave.sv */
`default_nettype none
module ssm_slave (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       nine_bit_i,
	input  wire logic       tx_load_i,
	input  wire logic [8:0] tx_data_i,
	input  wire logic       tx_drive_i,
	output logic      [8:0] rx_data_o,
	output logic            rx_valid_o,
	ssm_link_if.slv         link
);
	typedef struct packed {
		logic       ck_s1;
		logic       ck_s2;
		logic       ck_s3;
		logic       dt_s1;
		logic       dt_s2;
		logic [8:0] tx_sh;
		logic [8:0] rx_sh;
		logic [3:0] cnt;
		logic [8:0] rx_data;
		logic       rx_valid;
		logic       dt;
	} ssm_slv_s;

	ssm_slv_s s_r;
	ssm_slv_s s_nxt;

	logic       rise;
	logic       fall;
	logic [3:0] nbits;
	logic [8:0] rx_new;

	always_comb begin
		// Only the master's clock moves this end; it has no clock of its own
		rise   = s_r.ck_s2 & ~s_r.ck_s3;
		fall   = ~s_r.ck_s2 & s_r.ck_s3;
		nbits  = nine_bit_i ? ssm_pkg::BITS_NINE : ssm_pkg::BITS_NORMAL;
		rx_new = {s_r.dt_s2, s_r.rx_sh[8:1]};
		s_nxt  = s_r;
		s_nxt.ck_s1 = link.ck;
		s_nxt.ck_s2 = s_r.ck_s1;
		s_nxt.ck_s3 = s_r.ck_s2;
		s_nxt.dt_s1 = link.dt;
		s_nxt.dt_s2 = s_r.dt_s1;
		s_nxt.rx_valid = 1'b0;
		if (rise)
			s_nxt.dt = s_r.tx_sh[0];
		if (fall) begin
			s_nxt.rx_sh = rx_new;
			s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]};
			s_nxt.cnt   = s_r.cnt + 4'h1;
			// No framing bits, so a character ends purely by bit count
			if (s_r.cnt + 4'h1 == nbits) begin
				s_nxt.cnt      = 4'h0;
				s_nxt.rx_valid = 1'b1;
				s_nxt.rx_data  = nine_bit_i ? rx_new : {1'b0, rx_new[8:1]};
			end
		end
		if (tx_load_i)
			s_nxt.tx_sh = tx_data_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r       <= '0;
			s_r.dt_s1 <= 1'b1;
			s_r.dt_s2 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_data_o      = s_r.rx_data;
	assign rx_valid_o     = s_r.rx_valid;
	assign link.slv_dt_o  = s_r.dt;
	assign link.slv_dt_oe = tx_drive_i;
endmodule // ssm_slave
`default_nettype wire

/* testbench/ssm_link_chk.sv */
`default_nettype none
module ssm_link_chk (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic dev_ck_o,
	input  wire logic dev_ck_oe,
	input  wire logic dev_dt_o,
	input  wire logic dev_dt_oe,
	input  wire logic slv_dt_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_dt_on_rise;
		dev_dt_oe && $past(dev_dt_oe) && !$stable(dev_dt_o) |-> $rose(dev_ck_o);
	endproperty
	a_dt_on_rise: assert property (p_dt_on_rise) else $error("data moved off a rise");
	property p_ck_high;
		$rose(dev_ck_o) |-> dev_ck_o [*4];
	endproperty
	a_ck_high: assert property (p_ck_high) else $error("clock high too short");
	property p_ck_low;
		$fell(dev_ck_o) |-> !dev_ck_o [*4];
	endproperty
	a_ck_low: assert property (p_ck_low) else $error("clock low too short");
	property p_one_rise;
		$rose(dev_ck_o) |=> !$rose(dev_ck_o) [*7];
	endproperty
	a_one_rise: assert property (p_one_rise) else $error("clock period too short");
	property p_dt_needs_ck;
		dev_dt_oe |-> dev_ck_oe;
	endproperty
	a_dt_needs_ck: assert property (p_dt_needs_ck) else $error("data driven, clock not");
	property p_no_fight;
		!(dev_dt_oe && slv_dt_oe);
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
	property p_reset_quiet;
		$rose(rst_n_i) |-> !dev_ck_oe && !dev_dt_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("drivers on after reset");
	property p_ck_needs_oe;
		$rose(dev_ck_o) |-> dev_ck_oe;
	endproperty
	a_ck_needs_oe: assert property (p_ck_needs_oe) else $error("clock pulse undriven");
endmodule // ssm_link_chk
`default_nettype wire

/* testbench/ssm_port_tb_top.sv */
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module ssm_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_ready;
	logic        tx_irq;
	logic        nine = 1'b0;
	logic        load = 1'b0;
	logic [8:0]  tdata = 9'h000;
	logic        drive = 1'b0;
	logic [8:0]  rx_data;
	logic        rx_valid;
	logic        ck_q = 1'b0;
	logic        err;
	logic [31:0] rd;
	logic        bits[$];
	logic [8:0]  rxq[$];
	int          rises[$];
	int          cyc = 0;
	int          num_errors = 0;
	int          check_count = 0;
	ssm_link_if ssm_link_if_i ();
	ssm_port ssm_port_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_ready_o(tx_ready),
		.tx_irq_o(tx_irq), .link(ssm_link_if_i));
	ssm_slave ssm_slave_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .nine_bit_i(nine),
		.tx_load_i(load), .tx_data_i(tdata), .tx_drive_i(drive), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .link(ssm_link_if_i));
	ssm_link_chk ssm_link_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.dev_ck_o(ssm_link_if_i.dev_ck_o), .dev_ck_oe(ssm_link_if_i.dev_ck_oe),
		.dev_dt_o(ssm_link_if_i.dev_dt_o), .dev_dt_oe(ssm_link_if_i.dev_dt_oe),
		.slv_dt_oe(ssm_link_if_i.slv_dt_oe));
	always #2 clk_i = ~clk_i;
	// Sampled mid-cycle so link values have settled
	always @(negedge clk_i) begin
		cyc++;
		if (ssm_link_if_i.ck && !ck_q)
			rises.push_back(cyc);
		// Taken at the trailing edge: a slave only moves its bit a few cycles after the rise
		if (!ssm_link_if_i.ck && ck_q)
			bits.push_back(ssm_link_if_i.dt);
		ck_q = ssm_link_if_i.ck;
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (cyc > 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// Bits LSB first, rise spacing equals one bit period
	task automatic frame(input logic [8:0] v, input int n, input int per);
		logic b;
		while (bits.size() < n) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			b = bits.pop_front();
			`CHK(b, v[i])
		end
		for (int i = 1; i < n; i++) `CHK(rises[i] - rises[i-1], per)
		repeat (n) void'(rises.pop_front());
	endtask
	task automatic rx_chk(input logic [8:0] e);
		logic [8:0] v;
		v = (rxq.size() > 0) ? rxq.pop_front() : 9'h1FF;
		`CHK(v, e)
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rchk(ssm_pkg::ADDR_CTRL, 32'h0000_0000);
		rchk(ssm_pkg::ADDR_BAUD, 32'h0000_000F);
		rchk(ssm_pkg::ADDR_STATUS, 32'h0000_0001);
		`CHK(tx_irq, 1'b0)
		rchk(8'h14, 32'h0000_0000);
		`CHK(err, 1'b1)
		$display("test reset done");
		apb(1'b1, ssm_pkg::ADDR_BAUD, 32'h0000_0003);
		apb(1'b1, ssm_pkg::ADDR_CTRL, 32'h0000_0327);
		apb(1'b1, ssm_pkg::ADDR_TXDATA, 32'h0000_00A5);
		apb(1'b1, ssm_pkg::ADDR_TXDATA, 32'h0000_003C);
		`CHK(tx_ready, 1'b0)
		`CHK(tx_irq, 1'b0)
		frame(9'h0A5, 8, 8);
		frame(9'h03C, 8, 8);
		repeat (100) @(posedge clk_i);
		`CHK(bits.size(), 0)
		`CHK(tx_irq, 1'b1)
		rx_chk(9'h0A5);
		rx_chk(9'h03C);
		$display("test back to back done");
		nine <= 1'b1;
		apb(1'b1, ssm_pkg::ADDR_CTRL, 32'h0000_00E7);
		apb(1'b1, ssm_pkg::ADDR_TXDATA, 32'h0000_005A);
		frame(9'h15A, 9, 32);
		repeat (100) @(posedge clk_i);
		rx_chk(9'h15A);
		$display("test ninth bit done");
		// Transmit enable dropped so the data driver stays off after the frame
		apb(1'b1, ssm_pkg::ADDR_CTRL, 32'h0000_00CF);
		load <= 1'b1;
		tdata <= 9'h1C3;
		@(posedge clk_i);
		load <= 1'b0;
		drive <= 1'b1;
		frame(9'h1C3, 9, 32);
		repeat (100) @(posedge clk_i);
		rchk(ssm_pkg::ADDR_RXDATA, 32'h0000_01C3);
		rchk(ssm_pkg::ADDR_CTRL, 32'h0000_00C7);
		drive <= 1'b0;
		$display("test receive done");
		apb(1'b1, ssm_pkg::ADDR_CTRL, 32'h0000_00E3);
		apb(1'b1, ssm_pkg::ADDR_TXDATA, 32'h0000_0011);
		repeat (200) @(posedge clk_i);
		`CHK(bits.size(), 0)
		`CHK(ssm_link_if_i.dev_ck_oe, 1'b0)
		$display("test disable done");
		stop_test();
	end
endmodule // ssm_port_tb_top
`undef CHK
`default_nettype wire
